/* File: src/sdp_device.sv */
// Pin level command, address, clock gate and byte mask logic of a four bank DRAM
// Behaviour
// - every input pin is captured only on the rising clock edge.
// - burst counter and output data registers advance on the same clock.
// - clock gate high runs internal clocking, low stops it.
// - gated clock picks power-down, self refresh, active power-down or suspend by state.
// - clock gate sampled synchronously, but watched directly while powered down.
// - input buffers, clock gate excepted, are disabled in power-down and self refresh.
// - decoder enabled by chip select low; commands ignored while it is high.
// - with chip select high, running bursts finish and byte masks still act.
// - command decoded from chip select plus the three strobes together.
// - write lanes whose mask is high are dropped, memory byte unchanged.
// - read lanes with mask high go high impedance two clocks later.
// - mask bit n governs data bits 8n+7 to 8n.
// - bank select picks the bank for activate, read, write, precharge.
// - activate opens the row given on the address inputs.
// - read/write take column from low address bits; flag bit asks auto precharge.
// - precharge closes all banks if flag bit high, else selected bank.
// - load mode register takes its code from the address inputs.
// - 32-bit data bus carries one word per burst beat each way.
`timescale 1ns/1ps
module sdp_device (
  input wire logic clk,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdp_pkg::BANK_W-1:0] ba,
  input wire logic [sdp_pkg::ADDR_W-1:0] addr,
  input wire logic [sdp_pkg::LANES-1:0] dqm,
  input wire logic [sdp_pkg::DATA_W-1:0] dq_in,
  output logic [sdp_pkg::DATA_W-1:0] dq_out,
  output logic [sdp_pkg::LANES-1:0] dq_oe_n,
  output logic input_buf_en,
  output sdp_pkg::sdp_pwr_t pwr_state,
  output logic [sdp_pkg::ADDR_W-1:0] mode_code,
  output logic [sdp_pkg::BANKS-1:0] row_open,
  output logic burst_active
);
  import sdp_pkg::*;

  // Sampled pins
  logic cke_r, cke_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [BANK_W-1:0] ba_r, ba_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [LANES-1:0] dqm_r, dqm_nxt;
  logic [DATA_W-1:0] dqi_r, dqi_nxt;

  // Power state
  sdp_pwr_t pwr_r, pwr_nxt;
  logic en;

  // Bank and mode state
  logic [BANKS-1:0] open_r, open_nxt;
  logic [ADDR_W-1:0] row_r [BANKS];
  logic [ADDR_W-1:0] row_nxt [BANKS];
  logic [ADDR_W-1:0] mode_r, mode_nxt;

  // Burst state
  logic bst_act_r, bst_act_nxt;
  logic bst_wr_r, bst_wr_nxt;
  logic bst_ap_r, bst_ap_nxt;
  logic [COL_W-1:0] bst_cnt_r, bst_cnt_nxt;
  logic [COL_W-1:0] bst_col_r, bst_col_nxt;
  logic [BANK_W-1:0] bst_bank_r, bst_bank_nxt;

  // Beat of this cycle
  logic start, cont, b_wr, go, last, rd_go;
  logic [COL_W-1:0] b_col, b_cnt;
  logic [BANK_W-1:0] b_bank;
  logic [ARR_IDX_W-1:0] b_idx;

  // Read pipeline and lane enables
  logic [READ_LAT-1:0] rdv_r, rdv_nxt;
  logic [DATA_W-1:0] rdd_r [READ_LAT];
  logic [DATA_W-1:0] rdd_nxt [READ_LAT];
  logic [LANES-1:0] dqm_d_r, dqm_d_nxt;
  logic [LANES-1:0] oe_n_r, oe_n_nxt;

  // Array storage
  logic [DATA_W-1:0] mem_r [ARR_DEPTH];
  logic [DATA_W-1:0] mem_nxt [ARR_DEPTH];
  logic [DATA_W-1:0] merged;

  sdp_beat_if wq_in();
  sdp_beat_if wq_out();

  // The gate is registered every edge; other inputs and commands load only when buffers are on
  always_comb begin
    cke_nxt = cke;
    cmd_nxt = CMD_NOP;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    dqm_nxt = dqm_r;
    dqi_nxt = dqi_r;
    if (input_buf_en) begin
      cmd_nxt = {cs_n, ras_n, cas_n, we_n};
      ba_nxt = ba;
      addr_nxt = addr;
      dqm_nxt = dqm;
      dqi_nxt = dq_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cke_r <= 1'b1;
      cmd_r <= CMD_NOP;
      ba_r <= '0;
      addr_r <= '0;
      dqm_r <= '1;
      dqi_r <= DATA_RST;
    end else begin
      cke_r <= cke_nxt;
      cmd_r <= cmd_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dqm_r <= dqm_nxt;
      dqi_r <= dqi_nxt;
    end
  end

  // Internal clocking runs only with the gate high and no low-power state
  assign en = cke_r & (pwr_r == PS_RUN);
  assign input_buf_en = (pwr_r != PS_ACT_PD) & (pwr_r != PS_PRE_PD) &
                        (pwr_r != PS_SELF_REF);

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PS_RUN: begin
        if (!cke_r) begin
          if (bst_act_r) begin
            pwr_nxt = PS_SUSPEND;
          end else if (|open_r) begin
            pwr_nxt = PS_ACT_PD;
          end else if (cmd_r == CMD_REF) begin
            pwr_nxt = PS_SELF_REF;
          end else begin
            pwr_nxt = PS_PRE_PD;
          end
        end
      end
      PS_SUSPEND: begin
        if (cke_r) begin
          pwr_nxt = PS_RUN;
        end
      end
      PS_ACT_PD, PS_PRE_PD, PS_SELF_REF: begin
        // Other input registers hold and the command register loads NOP here; the raw gate pin is watched
        if (cke) begin
          pwr_nxt = PS_RUN;
        end
      end
      default: pwr_nxt = PS_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_r <= PS_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Beat selection: a new column command restarts, a burst stop ends it, otherwise the burst runs on
  // even with chip select high, since only the decoder is masked
  assign start = en & ((cmd_r == CMD_RD) | (cmd_r == CMD_WR)) & open_r[ba_r];
  assign cont = en & bst_act_r & ~start & (cmd_r != CMD_BST);
  assign b_wr = start ? (cmd_r == CMD_WR) : bst_wr_r;
  assign b_col = start ? addr_r[COL_W-1:0] : bst_col_r + bst_cnt_r;
  assign b_cnt = start ? '0 : bst_cnt_r;
  assign b_bank = start ? ba_r : bst_bank_r;
  assign b_idx = {b_bank, row_r[b_bank][0], b_col[ARR_COL_W-1:0]};
  // A full beat buffer holds the burst counter rather than losing a word
  assign go = (start | cont) & (~b_wr | wq_in.ready);
  assign last = go & (b_cnt == BURST_BEATS - 8'h01);
  assign rd_go = go & ~b_wr;

  always_comb begin
    open_nxt = open_r;
    row_nxt = row_r;
    mode_nxt = mode_r;
    bst_act_nxt = bst_act_r;
    bst_wr_nxt = bst_wr_r;
    bst_ap_nxt = bst_ap_r;
    bst_cnt_nxt = bst_cnt_r;
    bst_col_nxt = bst_col_r;
    bst_bank_nxt = bst_bank_r;
    if (en) begin
      case (cmd_r)
        CMD_ACT: begin
          open_nxt[ba_r] = 1'b1;
          row_nxt[ba_r] = addr_r;
        end
        CMD_PRE: begin
          if (addr_r[PRE_FLAG_POS]) begin
            open_nxt = '0;
          end else begin
            open_nxt[ba_r] = 1'b0;
          end
        end
        CMD_LMR: mode_nxt = addr_r;
        CMD_BST: bst_act_nxt = 1'b0;
        default: mode_nxt = mode_r;
      endcase
    end
    if (start) begin
      bst_act_nxt = 1'b1;
      bst_wr_nxt = b_wr;
      bst_ap_nxt = addr_r[PRE_FLAG_POS];
      bst_col_nxt = addr_r[COL_W-1:0];
      bst_bank_nxt = ba_r;
    end
    if (start | cont) begin
      bst_cnt_nxt = go ? b_cnt + 8'h01 : b_cnt;
    end
    if (last) begin
      bst_act_nxt = 1'b0;
      if (start ? addr_r[PRE_FLAG_POS] : bst_ap_r) begin
        open_nxt[b_bank] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      open_r <= '0;
      row_r <= '{default: ROW_RST};
      mode_r <= MODE_RST;
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_ap_r <= 1'b0;
      bst_cnt_r <= '0;
      bst_col_r <= '0;
      bst_bank_r <= '0;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      mode_r <= mode_nxt;
      bst_act_r <= bst_act_nxt;
      bst_wr_r <= bst_wr_nxt;
      bst_ap_r <= bst_ap_nxt;
      bst_cnt_r <= bst_cnt_nxt;
      bst_col_r <= bst_col_nxt;
      bst_bank_r <= bst_bank_nxt;
    end
  end

  // Write beats enter the buffer with the mask sampled in the same edge
  assign wq_in.valid = go & b_wr;
  assign wq_in.beat = '{idx: b_idx, data: dqi_r, be: ~dqm_r};
  // The array has one port; a read beat takes it and stalls the drain
  assign wq_out.ready = ~rd_go;

  sdp_fifo2 u_fifo (
    .clk(clk),
    .srst(srst),
    .in_b(wq_in.snk),
    .out_b(wq_out.src)
  );

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign merged[l*LANE_W +: LANE_W] = wq_out.beat.be[l] ?
      wq_out.beat.data[l*LANE_W +: LANE_W] :
      mem_r[wq_out.beat.idx][l*LANE_W +: LANE_W];
  end

  always_comb begin
    mem_nxt = mem_r;
    if (wq_out.valid & wq_out.ready) begin
      mem_nxt[wq_out.beat.idx] = merged;
    end
  end

  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
  end

  // Read data and delayed masks move only on enabled clocks; lane enables register every clock
  always_comb begin
    rdv_nxt = rdv_r;
    rdd_nxt = rdd_r;
    dqm_d_nxt = dqm_d_r;
    if (en) begin
      rdv_nxt[0] = rd_go;
      rdd_nxt[0] = mem_r[b_idx];
      for (int i = 1; i < READ_LAT; i++) begin
        rdv_nxt[i] = rdv_r[i-1];
        rdd_nxt[i] = rdd_r[i-1];
      end
      dqm_d_nxt = dqm_r;
    end
    // Mask sampled at edge k reaches the lane enable at edge k+2
    oe_n_nxt = ~{LANES{rdv_nxt[READ_LAT-1]}} | dqm_d_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdv_r <= '0;
      rdd_r <= '{default: DATA_RST};
      dqm_d_r <= '1;
      oe_n_r <= '1;
    end else begin
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
      dqm_d_r <= dqm_d_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign dq_out = rdd_r[READ_LAT-1];
  assign dq_oe_n = oe_n_r;
  assign pwr_state = pwr_r;
  assign mode_code = mode_r;
  assign row_open = open_r;
  assign burst_active = bst_act_r;
endmodule

/* File: include/sdp_pkg.sv */
// Shared constants and types for the synchronous DRAM pin command block
package sdp_pkg;
  localparam int ADDR_W = 12;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int PRE_FLAG_POS = 10;
  localparam int READ_LAT = 2;
  localparam int ARR_COL_W = 4;
  localparam int ARR_IDX_W = 7;
  localparam int ARR_DEPTH = 128;
  localparam int FIFO_DEPTH = 2;
  localparam logic [COL_W-1:0] BURST_BEATS = 8'h04;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [ADDR_W-1:0] ROW_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  // Command code is {chip select, row strobe, column strobe, write strobe}, all low active
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  typedef enum logic [2:0] {
    PS_RUN,
    PS_SUSPEND,
    PS_ACT_PD,
    PS_PRE_PD,
    PS_SELF_REF
  } sdp_pwr_t;

  typedef struct packed {
    logic [ARR_IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] be;
  } sdp_beat_t;
endpackage

/* File: include/sdp_beat_if.sv */
// Write beat carrier between the pin logic and its beat buffer
`timescale 1ns/1ps
interface sdp_beat_if;
  import sdp_pkg::*;
  logic valid;
  logic ready;
  sdp_beat_t beat;
  modport src(output valid, output beat, input ready);
  modport snk(input valid, input beat, output ready);
endinterface

/* File: src/sdp_fifo2.sv */
// Two-entry beat buffer with valid and ready on both sides
`timescale 1ns/1ps
module sdp_fifo2 (
  input wire logic clk,
  input wire logic srst,
  sdp_beat_if.snk in_b,
  sdp_beat_if.src out_b
);
  import sdp_pkg::*;

  sdp_beat_t mem_r [FIFO_DEPTH];
  sdp_beat_t mem_nxt [FIFO_DEPTH];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_b.ready = (cnt_r != 2'h2);
  assign out_b.valid = (cnt_r != 2'h0);
  assign out_b.beat = mem_r[rp_r];
  assign push = in_b.valid & in_b.ready;
  assign pop = out_b.valid & out_b.ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_b.beat;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    case ({push, pop})
      2'b10: cnt_nxt = cnt_r + 2'h1;
      2'b01: cnt_nxt = cnt_r - 2'h1;
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
    if (srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* File: verif/sdp_ctrl_model.sv */
// Controller model that drives the command, address, mask and data pins
`timescale 1ns/1ps
module sdp_ctrl_model (
  input wire logic clk,
  output logic cke,
  output logic [3:0] cmd,
  output logic [sdp_pkg::BANK_W-1:0] ba,
  output logic [sdp_pkg::ADDR_W-1:0] addr,
  output logic [sdp_pkg::LANES-1:0] dqm,
  output logic [sdp_pkg::DATA_W-1:0] dq
);
  import sdp_pkg::*;
  initial begin
    cke = 1'b1;
    cmd = CMD_NOP;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 4'h0;
    dq = 32'h0000_0000;
  end
  // Pins move at the falling edge only, so every rising edge sees them settled
  task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [1:0] b = 2'h0,
                       input logic [3:0] m = 4'h0, input logic [31:0] d = 32'h0000_0000);
    @(negedge clk);
    cmd = c;
    addr = a;
    ba = b;
    dqm = m;
    dq = d;
  endtask
  // Released data lines toggle so a stale word is never mistaken for a fresh one
  task automatic idle(input int n);
    repeat (n) issue(CMD_NOP, 12'h000, 2'h0, 4'h0, ~dq);
  endtask
  task automatic gate(input logic v);
    cke = v;
  endtask
endmodule

/* File: verif/sdp_device_checker.sv */
// Concurrent assertions on the pin command block
`timescale 1ns/1ps
module sdp_device_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdp_pkg::BANK_W-1:0] ba,
  input wire logic [sdp_pkg::ADDR_W-1:0] addr,
  input wire logic [sdp_pkg::LANES-1:0] dqm,
  input wire logic [sdp_pkg::LANES-1:0] dq_oe_n,
  input wire logic input_buf_en,
  input sdp_pkg::sdp_pwr_t pwr_state,
  input wire logic [sdp_pkg::ADDR_W-1:0] mode_code,
  input wire logic [sdp_pkg::BANKS-1:0] row_open,
  input wire logic burst_active
);
  import sdp_pkg::*;
  logic [3:0] cmd;
  logic go;
  logic cke_d;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // A gate drop taken one edge earlier already stops the next cycle, so go needs both
  always_ff @(posedge clk) begin
    cke_d <= cke;
  end
  assign go = cke && cke_d && (pwr_state == PS_RUN);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_cs_hold: assert property (cs_n |-> ##2 $stable(mode_code))
    else $error("mode code moved on a deselected cycle");
  a_lmr_load: assert property (go && cmd == CMD_LMR |-> ##2 mode_code == $past(addr, 2))
    else $error("mode code differs from load address");
  a_act_open: assert property (go && cmd == CMD_ACT |-> ##2 row_open[$past(ba, 2)])
    else $error("activated bank not open");
  a_pre_all: assert property (go && cmd == CMD_PRE && addr[PRE_FLAG_POS]
                              |-> ##2 row_open == 4'h0)
    else $error("precharge all left a bank open");
  a_pre_bank: assert property (go && cmd == CMD_PRE |-> ##2 !row_open[$past(ba, 2)])
    else $error("precharged bank still open");
  a_rd_start: assert property (go && cmd == CMD_RD ##1 row_open[$past(ba)]
                               |=> burst_active)
    else $error("read did not start a burst");
  a_mask_hiz: assert property ((go && dqm[3]) ##1 go ##1 go |=> dq_oe_n[3])
    else $error("masked read lane still driven");
  a_buf_state: assert property (input_buf_en == (pwr_state inside {PS_RUN, PS_SUSPEND}))
    else $error("input buffer enable wrong for power state");
  a_gate_suspend: assert property (!cke && pwr_state == PS_RUN && burst_active
                                   |-> ##2 pwr_state == PS_SUSPEND)
    else $error("gated burst not suspended");
  a_pd_exit: assert property (pwr_state inside {PS_ACT_PD, PS_PRE_PD, PS_SELF_REF} && cke
                              |=> pwr_state == PS_RUN)
    else $error("power down not left on gate high");
  c_write: cover property (go && cmd == CMD_WR);
  c_beat: cover property (burst_active && dq_oe_n == 4'h0);
  c_selfref: cover property (pwr_state == PS_SELF_REF);
  c_suspend: cover property (pwr_state == PS_SUSPEND);
endmodule
bind sdp_device sdp_device_checker sdp_device_checker_inst (.clk(clk), .srst(srst), .cke(cke),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
  .dq_oe_n(dq_oe_n), .input_buf_en(input_buf_en), .pwr_state(pwr_state),
  .mode_code(mode_code), .row_open(row_open), .burst_active(burst_active));

/* File: verif/tb.sv */
// Self-checking bench for the pin command block
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); \
  end \
end
module tb;
  import sdp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cke;
  logic [3:0] cmd;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] dqm;
  logic [DATA_W-1:0] dq_in;
  logic [DATA_W-1:0] dq_out;
  logic [LANES-1:0] dq_oe_n;
  logic input_buf_en;
  sdp_pwr_t pwr_state;
  logic [ADDR_W-1:0] mode_code;
  logic [BANKS-1:0] row_open;
  logic burst_active;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sdp_ctrl_model sdp_ctrl_model_inst (.clk(clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr),
    .dqm(dqm), .dq(dq_in));
  sdp_device sdp_device_inst (.clk(clk), .srst(srst), .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]),
    .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .input_buf_en(input_buf_en), .pwr_state(pwr_state),
    .mode_code(mode_code), .row_open(row_open), .burst_active(burst_active));
  task automatic op(input logic [3:0] c, input logic [11:0] a, input logic [1:0] b = 2'h0,
                    input logic [3:0] m = 4'h0, input logic [31:0] d = 32'h0000_0000);
    sdp_ctrl_model_inst.issue(c, a, b, m, d);
  endtask
  task automatic idle(input int n);
    sdp_ctrl_model_inst.idle(n);
  endtask
  task automatic t_lmr_cs();
    op(CMD_LMR, 12'h5a3);
    idle(2);
    `CHK("mode", 12'h5a3, mode_code)
    // Every code with chip select high, load and activate included
    for (int c = 8; c < 16; c++) begin
      op(4'(c), 12'hfff, 2'h2);
    end
    idle(2);
    `CHK("mode deselected", 12'h5a3, mode_code)
    `CHK("rows deselected", 4'h0, row_open)
  endtask
  task automatic t_data();
    logic [3:0] rm [4] = '{4'h0, 4'h8, 4'h4, 4'h1};
    logic [31:0] lm;
    int k;
    op(CMD_ACT, 12'h001, 2'h1);
    idle(2);
    `CHK("row", 4'h2, row_open)
    // Second burst masks lane 1, so that byte must keep the first burst's zero
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        op(i == 0 ? CMD_WR : 4'hf, 12'h010, 2'h1, j == 1 ? 4'h2 : 4'h0,
           (j == 1 ? 32'h5a5a_ff00 : 32'ha5a5_0000) + 32'(i));
      end
    end
    idle(4);
    // Read with auto precharge; beats run on with chip select high
    for (int i = 0; i < 7; i++) begin
      op(i == 0 ? CMD_RD : 4'hf, 12'h410, 2'h1, i < 4 ? rm[i] : 4'h0);
      if (i >= 3) begin
        k = i - 3;
        lm = {{8{~rm[k][3]}}, {8{~rm[k][2]}}, {8{~rm[k][1]}}, {8{~rm[k][0]}}};
        `CHK("oe", rm[k], dq_oe_n)
        `CHK("data", (32'h5a5a_0000 + 32'(k)) & lm, dq_out & lm)
      end
    end
    idle(3);
    `CHK("auto precharge", 4'h0, row_open)
    `CHK("burst done", 1'b0, burst_active)
  endtask
  task automatic t_pwr();
    op(CMD_ACT, 12'h003, 2'h3);
    op(CMD_ACT, 12'h002, 2'h0);
    idle(2);
    sdp_ctrl_model_inst.gate(1'b0);
    idle(2);
    `CHK("active pd", PS_ACT_PD, pwr_state)
    `CHK("buf off", 1'b0, input_buf_en)
    sdp_ctrl_model_inst.gate(1'b1);
    idle(2);
    `CHK("pd exit", PS_RUN, pwr_state)
    op(CMD_RD, 12'h000, 2'h3);
    idle(2);
    sdp_ctrl_model_inst.gate(1'b0);
    idle(2);
    `CHK("suspend", PS_SUSPEND, pwr_state)
    sdp_ctrl_model_inst.gate(1'b1);
    // Stop lands before the last two beats, so an ignored stop leaves the burst running
    op(CMD_BST, 12'h000);
    idle(2);
    `CHK("stopped", 1'b0, burst_active)
    op(CMD_PRE, 12'h000, 2'h3);
    idle(2);
    `CHK("one bank", 4'h1, row_open)
    op(CMD_PRE, 12'h400, 2'h2);
    idle(2);
    `CHK("all banks", 4'h0, row_open)
    sdp_ctrl_model_inst.gate(1'b0);
    idle(2);
    `CHK("precharge pd", PS_PRE_PD, pwr_state)
    sdp_ctrl_model_inst.gate(1'b1);
    idle(2);
    op(CMD_REF, 12'h000);
    sdp_ctrl_model_inst.gate(1'b0);
    idle(2);
    `CHK("self refresh", PS_SELF_REF, pwr_state)
    sdp_ctrl_model_inst.gate(1'b1);
    idle(2);
    `CHK("buf on", 1'b1, input_buf_en)
  endtask
  task automatic t_reset();
    op(CMD_ACT, 12'h007, 2'h2);
    idle(2);
    `CHK("row before reset", 4'h4, row_open)
    // Reset in mid-run must clear open rows and the stored mode code
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    idle(1);
    `CHK("mid reset rows", 4'h0, row_open)
    `CHK("mid reset mode", 12'h000, mode_code)
    `CHK("mid reset oe", 4'hf, dq_oe_n)
    `CHK("mid reset pwr", PS_RUN, pwr_state)
    op(CMD_ACT, 12'h001, 2'h3);
    idle(2);
    `CHK("row after reset", 4'h8, row_open)
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The run needs about 80 cycles; this ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    idle(1);
    `CHK("reset oe", 4'hf, dq_oe_n)
    `CHK("reset pwr", PS_RUN, pwr_state)
    `CHK("reset rows", 4'h0, row_open)
    t_lmr_cs();
    t_data();
    t_pwr();
    t_reset();
    end_sim();
  end
endmodule
